// *** design/stack_sleep_wake_consts.vh ***
// Timing figures and command codes for the stack sleep and wake control
`ifndef STACK_SLEEP_WAKE_CONSTS_VH
`define STACK_SLEEP_WAKE_CONSTS_VH

// Clock rate in kHz (50 ns period)
`define CLK_KHZ 20000

// Longest sleep wait per chain rate, in microseconds
`define SLEEP_WAIT_1000K_US 500
`define SLEEP_WAIT_500K_US 2000
`define SLEEP_WAIT_333K_US 4000

// Wake time allowed per stacked device, in microseconds
`define WAKE_PER_DEV_US 14500

// Wake line pattern: driven high this long, detected after this long
`define WAKE_TX_US 100
`define WAKE_DET_US 50

// Chain rate select codes
`define RATE_1000K 2'h0
`define RATE_500K 2'h1
`define RATE_333K 2'h2

// Decoded command codes
`define CMD_SLEEP 4'h1
`define CMD_WAKEUP 4'h2
`define CMD_PRECURSOR 4'h3
`define CMD_HARD_STACK_RESET_CMD 4'h4

// Control state encodings
`define ST_AWAKE 3'h0
`define ST_WAIT 3'h1
`define ST_SLEEP 3'h2
`define ST_SCAN 3'h3
`define ST_WAKE_TX 3'h4
`define ST_SETTLE 3'h5

`endif

// *** design/stack_sleep_wake_control.v ***
// Sleep entry, wake and wake-acknowledge control for one stacked device
`timescale 1ns/10ps
`default_nettype none
`include "stack_sleep_wake_consts.vh"

module stack_sleep_wake_control #(
	parameter integer CW = 24,
	parameter integer SLEEP_CYC_1000K =
		`SLEEP_WAIT_1000K_US * `CLK_KHZ / 1000,
	parameter integer SLEEP_CYC_500K = `SLEEP_WAIT_500K_US * `CLK_KHZ / 1000,
	parameter integer SLEEP_CYC_333K = `SLEEP_WAIT_333K_US * `CLK_KHZ / 1000,
	parameter integer WAKE_DEV_CYC = `WAKE_PER_DEV_US * `CLK_KHZ / 1000
) (
	input wire clk_i,
	input wire nrst_i,
	input wire ce_i,
	input wire is_master_i,
	input wire is_top_i,
	input wire [4:0] stack_size_i,
	input wire [1:0] rate_sel_i,
	input wire cmd_valid_i,
	input wire [3:0] cmd_code_i,
	input wire cmd_broadcast_i,
	input wire cmd_crc_ok_i,
	input wire dn_frame_valid_i,
	input wire ack_rx_i,
	input wire fault_resp_rx_i,
	input wire host_resp_read_i,
	input wire wdog_expire_i,
	input wire osc_fault_i,
	input wire over_temp_i,
	input wire balance_done_i,
	input wire scan_cont_i,
	input wire scan_tick_i,
	input wire scan_done_i,
	input wire fault_det_i,
	input wire dn_wake_line_i,
	input wire up_wake_line_i,
	output reg asleep_o,
	output reg scan_wake_o,
	output reg up_wake_tx_o,
	output reg dn_wake_tx_o,
	output reg ack_dn_o,
	output reg host_ack_o,
	output reg nak_o,
	output reg hard_stack_reset_cmd_pass_o,
	output reg fault_resp_send_o,
	output reg host_response_pending_n_o
);

	localparam [CW-1:0] WAKE_TX_CYC = `WAKE_TX_US * `CLK_KHZ / 1000;
	localparam [CW-1:0] WAKE_DET_CYC = (`WAKE_DET_US * `CLK_KHZ + 999) / 1000;

	// Sleep wait length for the chain rate
	function [CW-1:0] sleep_cyc;
		input [1:0] rate;
		begin
			case (rate)
			`RATE_500K: sleep_cyc = SLEEP_CYC_500K[CW-1:0];
			`RATE_333K: sleep_cyc = SLEEP_CYC_333K[CW-1:0];
			default: sleep_cyc = SLEEP_CYC_1000K[CW-1:0];
			endcase
		end
	endfunction

	// Per-device wake time times devices above the first
	function [CW-1:0] stack_cyc;
		input [4:0] n;
		reg [31:0] prod;
		begin
			prod = WAKE_DEV_CYC * ((n == 5'h00) ? 0 : n - 1);
			stack_cyc = prod[CW-1:0];
		end
	endfunction

	reg dn_s1_r, dn_s2_r, dn_s3_r, dn_filt_r;
	reg up_s1_r, up_s2_r, up_s3_r, up_filt_r;
	reg [CW-1:0] dn_hi_r, up_hi_r;
	reg dn_det_r, up_det_r;
	reg [2:0] state_r, state_nxt;
	reg [CW-1:0] cnt_r, cnt_nxt;
	reg trap_r, trap_nxt;
	reg scan_on_r, scan_on_nxt;
	reg bal_done_r, bal_done_nxt;
	reg fault_org_r, fault_org_nxt;
	reg fwd_up_r, fwd_up_nxt;
	reg fwd_dn_r, fwd_dn_nxt;
	reg ack_dn_nxt, host_ack_nxt, nak_nxt, hard_stack_reset_cmd_nxt, fresp_nxt;
	reg pend_set;
	wire dn_valid;
	wire cmd_ok;

	assign dn_valid = dn_frame_valid_i & ~up_wake_tx_o;
	assign cmd_ok = cmd_valid_i & cmd_crc_ok_i;

	// Wake line inputs: three stages, change taken once last two agree
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dn_s1_r <= 1'b0;
			dn_s2_r <= 1'b0;
			dn_s3_r <= 1'b0;
			dn_filt_r <= 1'b0;
			up_s1_r <= 1'b0;
			up_s2_r <= 1'b0;
			up_s3_r <= 1'b0;
			up_filt_r <= 1'b0;
		end else if (ce_i) begin
			dn_s1_r <= dn_wake_line_i;
			dn_s2_r <= dn_s1_r;
			dn_s3_r <= dn_s2_r;
			up_s1_r <= up_wake_line_i;
			up_s2_r <= up_s1_r;
			up_s3_r <= up_s2_r;
			if (dn_s2_r == dn_s3_r) begin
				dn_filt_r <= dn_s3_r;
			end
			if (up_s2_r == up_s3_r) begin
				up_filt_r <= up_s3_r;
			end
		end
	end

	// wake pattern is a held-high line, no frame decode
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dn_hi_r <= {CW{1'b0}};
			up_hi_r <= {CW{1'b0}};
			dn_det_r <= 1'b0;
			up_det_r <= 1'b0;
		end else if (ce_i) begin
			dn_hi_r <= dn_filt_r ? ((dn_hi_r == WAKE_DET_CYC) ? dn_hi_r :
				dn_hi_r + 1'b1) : {CW{1'b0}};
			up_hi_r <= up_filt_r ? ((up_hi_r == WAKE_DET_CYC) ? up_hi_r :
				up_hi_r + 1'b1) : {CW{1'b0}};
			dn_det_r <= (dn_hi_r == WAKE_DET_CYC - 1'b1);
			up_det_r <= (up_hi_r == WAKE_DET_CYC - 1'b1);
		end
	end

	// Control state machine
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		trap_nxt = trap_r;
		scan_on_nxt = scan_on_r;
		bal_done_nxt = bal_done_r | balance_done_i;
		fault_org_nxt = fault_org_r;
		fwd_up_nxt = fwd_up_r;
		fwd_dn_nxt = fwd_dn_r;
		ack_dn_nxt = 1'b0;
		host_ack_nxt = 1'b0;
		nak_nxt = 1'b0;
		hard_stack_reset_cmd_nxt = 1'b0;
		fresp_nxt = 1'b0;
		pend_set = 1'b0;
		// precursor traps the next host command
		if (cmd_ok && is_master_i && trap_r) begin
			trap_nxt = 1'b0;
			if (cmd_code_i == `CMD_HARD_STACK_RESET_CMD) begin
				hard_stack_reset_cmd_nxt = 1'b1;
			end else if (cmd_code_i == `CMD_WAKEUP && cmd_broadcast_i) begin
				state_nxt = `ST_WAKE_TX;
				cnt_nxt = WAKE_TX_CYC;
				fault_org_nxt = 1'b0;
				fwd_up_nxt = 1'b1;
				fwd_dn_nxt = 1'b0;
			end else begin
				nak_nxt = 1'b1;
			end
		end else if (cmd_ok && is_master_i &&
				cmd_code_i == `CMD_PRECURSOR) begin
			// same trap whether asleep or awake
			trap_nxt = 1'b1;
		end else if (cmd_ok && is_master_i && cmd_code_i == `CMD_WAKEUP &&
				!cmd_broadcast_i) begin
			nak_nxt = 1'b1;
		end else begin
			case (state_r)
			`ST_AWAKE: begin
				if (wdog_expire_i || osc_fault_i || over_temp_i) begin
					state_nxt = `ST_SLEEP;
					scan_on_nxt = scan_cont_i;
				end else if (cmd_ok && cmd_broadcast_i &&
						cmd_code_i == `CMD_SLEEP) begin
					state_nxt = `ST_WAIT;
					cnt_nxt = sleep_cyc(rate_sel_i);
					bal_done_nxt = 1'b0;
				end else if (ack_rx_i && !is_master_i) begin
					ack_dn_nxt = 1'b1;
				end else if (ack_rx_i) begin
					host_ack_nxt = 1'b1;
					pend_set = 1'b1;
				end
			end
			`ST_WAIT: begin
				if (cmd_ok && cmd_broadcast_i &&
						cmd_code_i == `CMD_SLEEP) begin
					cnt_nxt = sleep_cyc(rate_sel_i);
				end else if (dn_valid) begin
					state_nxt = `ST_AWAKE;
				end else if (wdog_expire_i || osc_fault_i || over_temp_i ||
						cnt_r <= 1) begin
					state_nxt = `ST_SLEEP;
					scan_on_nxt = scan_cont_i;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			`ST_SLEEP, `ST_SCAN: begin
				if (dn_det_r || up_det_r) begin
					state_nxt = `ST_WAKE_TX;
					cnt_nxt = WAKE_TX_CYC;
					fault_org_nxt = 1'b0;
					fwd_up_nxt = dn_det_r;
					fwd_dn_nxt = up_det_r & ~is_master_i;
				end else if (cmd_ok && is_master_i && cmd_broadcast_i &&
						cmd_code_i == `CMD_WAKEUP) begin
					state_nxt = `ST_WAKE_TX;
					cnt_nxt = WAKE_TX_CYC;
					fault_org_nxt = 1'b0;
					fwd_up_nxt = 1'b1;
					fwd_dn_nxt = 1'b0;
				end else if (state_r == `ST_SCAN && fault_det_i) begin
					state_nxt = `ST_WAKE_TX;
					cnt_nxt = WAKE_TX_CYC;
					fault_org_nxt = 1'b1;
					fwd_up_nxt = 1'b1;
					fwd_dn_nxt = ~is_master_i;
				end else if (state_r == `ST_SCAN && scan_done_i) begin
					state_nxt = `ST_SLEEP;
				end else if (state_r == `ST_SLEEP && scan_on_r &&
						scan_tick_i) begin
					state_nxt = `ST_SCAN;
				end
			end
			`ST_WAKE_TX: begin
				if (cnt_r <= 1) begin
					state_nxt = `ST_SETTLE;
					cnt_nxt = stack_cyc(stack_size_i);
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			`ST_SETTLE: begin
				if (ack_rx_i && is_master_i) begin
					host_ack_nxt = 1'b1;
					pend_set = 1'b1;
				end
				if (!fault_org_r && !is_top_i) begin
					state_nxt = `ST_AWAKE;
				end else if (cnt_r <= 1) begin
					state_nxt = `ST_AWAKE;
					if (fault_org_r && is_master_i) begin
						pend_set = 1'b1;
					end else if (fault_org_r) begin
						fresp_nxt = 1'b1;
					end else begin
						ack_dn_nxt = 1'b1;
					end
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				state_nxt = `ST_AWAKE;
			end
			endcase
		end
		if (is_master_i && fault_resp_rx_i) begin
			pend_set = 1'b1;
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= `ST_AWAKE;
			cnt_r <= {CW{1'b0}};
			trap_r <= 1'b0;
			scan_on_r <= 1'b0;
			bal_done_r <= 1'b0;
			fault_org_r <= 1'b0;
			fwd_up_r <= 1'b0;
			fwd_dn_r <= 1'b0;
			asleep_o <= 1'b0;
			scan_wake_o <= 1'b0;
			up_wake_tx_o <= 1'b0;
			dn_wake_tx_o <= 1'b0;
			ack_dn_o <= 1'b0;
			host_ack_o <= 1'b0;
			nak_o <= 1'b0;
			hard_stack_reset_cmd_pass_o <= 1'b0;
			fault_resp_send_o <= 1'b0;
			host_response_pending_n_o <= 1'b1;
		end else if (ce_i) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			trap_r <= trap_nxt;
			scan_on_r <= scan_on_nxt;
			bal_done_r <= bal_done_nxt;
			fault_org_r <= fault_org_nxt;
			fwd_up_r <= fwd_up_nxt;
			fwd_dn_r <= fwd_dn_nxt;
			// only receivers and timing run asleep
			asleep_o <= (state_nxt == `ST_SLEEP);
			scan_wake_o <= (state_nxt == `ST_SCAN);
			up_wake_tx_o <= (state_nxt == `ST_WAKE_TX) & fwd_up_nxt;
			dn_wake_tx_o <= (state_nxt == `ST_WAKE_TX) & fwd_dn_nxt;
			ack_dn_o <= ack_dn_nxt;
			host_ack_o <= host_ack_nxt;
			nak_o <= nak_nxt;
			hard_stack_reset_cmd_pass_o <= hard_stack_reset_cmd_nxt;
			fault_resp_send_o <= fresp_nxt;
			// Set wins over host read
			if (pend_set) begin
				host_response_pending_n_o <= 1'b0;
			end else if (host_resp_read_i) begin
				host_response_pending_n_o <= 1'b1;
			end
		end
	end

endmodule // stack_sleep_wake_control
`default_nettype wire

// *** verification/sleep_wake_asserts.sv ***
// Assertion checker on the sleep and wake control ports
`timescale 1ns/10ps
`default_nettype none
module sleep_wake_asserts (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic is_master_i,
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_code_i,
	input wire logic cmd_broadcast_i,
	input wire logic cmd_crc_ok_i,
	input wire logic ack_rx_i,
	input wire logic fault_resp_rx_i,
	input wire logic host_resp_read_i,
	input wire logic asleep_o,
	input wire logic scan_wake_o,
	input wire logic up_wake_tx_o,
	input wire logic nak_o,
	input wire logic hard_stack_reset_cmd_pass_o,
	input wire logic host_ack_o,
	input wire logic host_response_pending_n_o
);
	logic pre_r;
	wire logic tk = ce_i && cmd_valid_i && cmd_crc_ok_i && is_master_i;
	// Precursor trap armed, cleared by the trapped command
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pre_r <= 1'h0;
		end else if (tk) begin
			pre_r <= !pre_r && cmd_code_i == 4'h3;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_crc; ce_i && cmd_valid_i && !cmd_crc_ok_i |=> !nak_o;
	endproperty
	a_crc: assert property (p_crc) else $error("bad crc answered");
	property p_adr; tk && cmd_code_i == 4'h2 && !cmd_broadcast_i |=> nak_o;
	endproperty
	a_adr: assert property (p_adr) else $error("no nak");
	property p_hr; tk && pre_r && cmd_code_i == 4'h4
		|=> hard_stack_reset_cmd_pass_o; endproperty
	a_hr: assert property (p_hr) else $error("reset not passed");
	property p_oth; tk && pre_r && cmd_code_i == 4'h1
		|=> nak_o; endproperty
	a_oth: assert property (p_oth) else $error("trap no nak");
	property p_wk; tk && pre_r && cmd_code_i == 4'h2
		&& cmd_broadcast_i |=> up_wake_tx_o && !asleep_o; endproperty
	a_wk: assert property (p_wk) else $error("no wake");
	property p_nw; tk && cmd_code_i == 4'h2 && !pre_r && !asleep_o
		&& !scan_wake_o && !up_wake_tx_o |=> !up_wake_tx_o; endproperty
	a_nw: assert property (p_nw) else $error("stray wake");
	property p_tx; $rose(up_wake_tx_o) |-> up_wake_tx_o [*8]; endproperty
	a_tx: assert property (p_tx) else $error("wake too short");
	property p_fr; ce_i && is_master_i && fault_resp_rx_i
		|=> !host_response_pending_n_o; endproperty
	a_fr: assert property (p_fr) else $error("pending not set");
	property p_ack; ce_i && is_master_i && ack_rx_i && !tk && !asleep_o
		&& !scan_wake_o && !up_wake_tx_o
		|=> host_ack_o && !host_response_pending_n_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not passed");
	c_wk: cover property (tk && pre_r && cmd_code_i == 4'h2 ##1 up_wake_tx_o);
	c_hr: cover property (tk && pre_r && cmd_code_i == 4'h4 ##1 hard_stack_reset_cmd_pass_o);
	c_scan: cover property ($rose(scan_wake_o));
	c_ack: cover property (ack_rx_i ##1 host_ack_o);
endmodule // sleep_wake_asserts
`default_nettype wire

// *** verification/upper_neighbour_model.sv ***
// Upper neighbour model that ACKs a finished upward wake
`timescale 1ns/10ps
`default_nettype none
module upper_neighbour_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic wake_i,
	output logic ack_o
);
	logic d_r;
	logic [4:0] cnt_r;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			d_r <= 1'h0;
			cnt_r <= 5'h0;
			ack_o <= 1'h0;
		end else begin
			d_r <= wake_i;
			ack_o <= cnt_r == 5'h1;
			if (d_r && !wake_i)
				cnt_r <= 5'h14;
			else if (cnt_r != 5'h0)
				cnt_r <= cnt_r - 5'h1;
		end
	end
endmodule // upper_neighbour_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the stack sleep and wake control
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk_i = 1'h0, nrst_i = 1'h0, cmd_valid_i = 1'h0;
	logic cmd_broadcast_i = 1'h0, cmd_crc_ok_i = 1'h0;
	logic [3:0] cmd_code_i = 4'h0;
	logic [1:0] rate_sel_i = 2'h0;
	logic dn_frame_valid_i = 1'h0, fault_resp_rx_i = 1'h0;
	logic host_resp_read_i = 1'h0, wdog_expire_i = 1'h0, osc_fault_i = 1'h0;
	logic over_temp_i = 1'h0, balance_done_i = 1'h0, scan_cont_i = 1'h0;
	logic scan_tick_i = 1'h0, scan_done_i = 1'h0, fault_det_i = 1'h0;
	logic dn_wake_line_i = 1'h0, up_wake_line_i = 1'h0;
	logic ce_i = 1'h1;
	wire asleep_o, up_wake_tx_o, nak_o, hard_stack_reset_cmd_pass_o, host_ack_o;
	wire host_response_pending_n_o, ack_rx_i;
	wire scan_wake_o, dn_wake_tx_o, ack_dn_o;
	int n_tests = 0, miscompares = 0, cyc = 0;
	stack_sleep_wake_control #(.SLEEP_CYC_1000K(40), .SLEEP_CYC_500K(60),
		.SLEEP_CYC_333K(80), .WAKE_DEV_CYC(200)) u_dut (.clk_i, .nrst_i,
		.ce_i, .is_master_i(1'h1), .is_top_i(1'h0),
		.stack_size_i(5'h2), .rate_sel_i, .cmd_valid_i, .cmd_code_i,
		.cmd_broadcast_i, .cmd_crc_ok_i, .dn_frame_valid_i, .ack_rx_i,
		.fault_resp_rx_i, .host_resp_read_i, .wdog_expire_i, .osc_fault_i,
		.over_temp_i, .balance_done_i, .scan_cont_i, .scan_tick_i,
		.scan_done_i, .fault_det_i, .dn_wake_line_i, .up_wake_line_i,
		.asleep_o, .scan_wake_o, .up_wake_tx_o, .dn_wake_tx_o,
		.ack_dn_o, .host_ack_o, .nak_o, .hard_stack_reset_cmd_pass_o,
		.fault_resp_send_o(), .host_response_pending_n_o);
	upper_neighbour_model u_up (.clk_i, .nrst_i, .wake_i(up_wake_tx_o),
		.ack_o(ack_rx_i));
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			test_done;
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic cmd(input logic [3:0] c, input logic b, input logic k);
		cmd_valid_i = 1'h1;
		cmd_code_i = c;
		cmd_broadcast_i = b;
		cmd_crc_ok_i = k;
		wt(1);
	endtask
	task automatic rd_pend;
		chk(host_response_pending_n_o, 1'h0);
		host_resp_read_i = 1'h1;
		wt(1);
		host_resp_read_i = 1'h0;
		chk(host_response_pending_n_o, 1'h1);
	endtask
	task automatic get_ack;
		for (int i = 0; i < 3000 && host_ack_o !== 1'h1; i++)
			wt(1);
		chk(host_ack_o, 1'h1);
		rd_pend;
	endtask
	task automatic host_wake;
		cmd(4'h3, 1'h1, 1'h1);
		cmd(4'h2, 1'h1, 1'h1);
		cmd_valid_i = 1'h0;
		chk(up_wake_tx_o, 1'h1);
		chk(asleep_o, 1'h0);
		chk(dn_wake_tx_o, 1'h0);
		wt(1990);
		chk(up_wake_tx_o, 1'h1);
		get_ack;
	endtask
	task automatic line_wake;
		dn_wake_line_i = 1'h1;
		wt(1010);
		chk(up_wake_tx_o, 1'h1);
		chk(asleep_o, 1'h0);
		dn_frame_valid_i = 1'h1;
		wt(1);
		dn_frame_valid_i = 1'h0;
		chk(up_wake_tx_o, 1'h1);
		wt(990);
		dn_wake_line_i = 1'h0;
		get_ack;
	endtask
	task automatic t_trap;
		cmd(4'h3, 1'h1, 1'h1);
		cmd(4'h4, 1'h1, 1'h1);
		chk(hard_stack_reset_cmd_pass_o, 1'h1);
		cmd(4'h3, 1'h1, 1'h1);
		cmd(4'h1, 1'h1, 1'h1);
		chk(nak_o, 1'h1);
		cmd(4'h2, 1'h0, 1'h1);
		chk(nak_o, 1'h1);
		cmd(4'h2, 1'h1, 1'h0);
		chk(nak_o, 1'h0);
		cmd(4'h2, 1'h1, 1'h1);
		cmd_valid_i = 1'h0;
		wt(2);
		chk(up_wake_tx_o, 1'h0);
		wt(90);
		chk(asleep_o, 1'h0);
		$display("trap test done");
	endtask
	task automatic t_sleep;
		for (int r = 0; r < 3; r++) begin
			rate_sel_i = r[1:0];
			cmd(4'h1, 1'h1, 1'h1);
			cmd_valid_i = 1'h0;
			wt(37 + 20 * r);
			chk(asleep_o, 1'h0);
			wt(5);
			chk(asleep_o, 1'h1);
			host_wake;
		end
		$display("sleep rate test done");
	endtask
	task automatic t_cancel;
		rate_sel_i = 2'h0;
		cmd(4'h1, 1'h1, 1'h1);
		cmd_valid_i = 1'h0;
		wt(20);
		cmd(4'h1, 1'h1, 1'h1);
		cmd_valid_i = 1'h0;
		wt(30);
		chk(asleep_o, 1'h0);
		dn_frame_valid_i = 1'h1;
		wt(1);
		dn_frame_valid_i = 1'h0;
		wt(60);
		chk(asleep_o, 1'h0);
		$display("cancel test done");
	endtask
	task automatic t_src;
		for (int k = 0; k < 3; k++) begin
			{wdog_expire_i, osc_fault_i, over_temp_i} = 3'h1 << k;
			wt(1);
			{wdog_expire_i, osc_fault_i, over_temp_i} = 3'h0;
			chk(asleep_o, 1'h1);
			if (k == 0)
				line_wake;
			else
				host_wake;
		end
		fault_resp_rx_i = 1'h1;
		wt(1);
		fault_resp_rx_i = 1'h0;
		rd_pend;
		$display("source test done");
	endtask
	task automatic t_freeze;
		rate_sel_i = 2'h0;
		cmd(4'h1, 1'h1, 1'h1);
		cmd_valid_i = 1'h0;
		wt(10);
		ce_i = 1'h0;
		wt(20);
		ce_i = 1'h1;
		wt(27);
		chk(asleep_o, 1'h0);
		wt(5);
		chk(asleep_o, 1'h1);
		host_wake;
		$display("freeze test done");
	endtask
	task automatic t_scan;
		scan_cont_i = 1'h1;
		wdog_expire_i = 1'h1;
		wt(1);
		wdog_expire_i = 1'h0;
		scan_cont_i = 1'h0;
		chk(asleep_o, 1'h1);
		scan_tick_i = 1'h1;
		wt(1);
		scan_tick_i = 1'h0;
		chk(scan_wake_o, 1'h1);
		chk(asleep_o, 1'h0);
		scan_done_i = 1'h1;
		wt(1);
		scan_done_i = 1'h0;
		chk(scan_wake_o, 1'h0);
		chk(asleep_o, 1'h1);
		scan_tick_i = 1'h1;
		wt(1);
		scan_tick_i = 1'h0;
		fault_det_i = 1'h1;
		wt(1);
		fault_det_i = 1'h0;
		chk(up_wake_tx_o, 1'h1);
		chk(dn_wake_tx_o, 1'h0);
		get_ack;
		wt(120);
		chk(host_response_pending_n_o, 1'h1);
		wt(70);
		chk(host_response_pending_n_o, 1'h0);
		chk(ack_dn_o, 1'h0);
		rd_pend;
		wdog_expire_i = 1'h1;
		wt(1);
		wdog_expire_i = 1'h0;
		chk(asleep_o, 1'h1);
		up_wake_line_i = 1'h1;
		wt(1010);
		chk(asleep_o, 1'h0);
		chk(up_wake_tx_o, 1'h0);
		chk(dn_wake_tx_o, 1'h0);
		wt(2010);
		up_wake_line_i = 1'h0;
		$display("scan test done");
	endtask
	initial begin
		wt(5);
		nrst_i = 1'h1;
		wt(1);
		chk(host_response_pending_n_o, 1'h1);
		t_trap;
		t_sleep;
		t_cancel;
		t_freeze;
		t_src;
		t_scan;
		test_done;
	end
endmodule // testbench
bind stack_sleep_wake_control sleep_wake_asserts u_chk (.clk_i, .nrst_i,
	.ce_i, .is_master_i, .cmd_valid_i, .cmd_code_i, .cmd_broadcast_i,
	.cmd_crc_ok_i, .ack_rx_i, .fault_resp_rx_i, .host_resp_read_i,
	.asleep_o, .scan_wake_o, .up_wake_tx_o, .nak_o, .hard_stack_reset_cmd_pass_o,
	.host_ack_o,
	.host_response_pending_n_o);
`default_nettype wire
